/* File: bpio_keypad.sv */
// far-side model of the pads: keypad switches on port b, plain loads on port c
`timescale 1ns/100ps
module bpio_keypad (
	input  wire logic       clk_i,
	input  wire logic [7:0] b_drive_i,
	input  wire logic [7:0] b_oe_i,
	input  wire logic [7:0] b_pullup_i,
	input  wire logic [7:0] key_en_i,
	input  wire logic [7:0] key_val_i,
	input  wire logic [7:0] c_drive_i,
	input  wire logic [7:0] c_oe_i,
	output logic      [7:0] b_level_o,
	output logic      [7:0] c_level_o
);
	// ----------------------------------------------------------------
	// pad resolution
	// ----------------------------------------------------------------
	logic [7:0] float_ff = 8'h5A;

	// undriven pads wander every cycle so a lost drive never reads clean
	always @(posedge clk_i) begin
		float_ff <= ~float_ff;
	end

	// a held key beats the pad driver; contention only when a test asks
	assign b_level_o = (key_en_i & key_val_i) | (~key_en_i & b_oe_i & b_drive_i)
		| (~key_en_i & ~b_oe_i & b_pullup_i) | (~key_en_i & ~b_oe_i & ~b_pullup_i & float_ff);
	// port c has no pull-ups, so released lines float
	assign c_level_o = (c_oe_i & c_drive_i) | (~c_oe_i & float_ff);
endmodule

/* File: bpio_pin.sv */
// one 8-bit port: direction, latch, pin drive and pull-up control
`timescale 1ns/100ps
module bpio_pin #(
	parameter int         W       = 8,
	parameter logic [7:0] DIR_RST = 8'hFF
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic         dir_we_i,
	input  wire logic         lat_we_i,
	input  wire logic [W-1:0] wdata_i,
	input  wire logic [W-1:0] pins_i,
	input  wire logic         pu_en_n_i,
	output logic      [W-1:0] dir_o,
	output logic      [W-1:0] lat_o,
	output logic      [W-1:0] out_o,
	output logic      [W-1:0] oe_o,
	output logic      [W-1:0] pu_o
);
	logic [W-1:0] dir_ff;
	logic [W-1:0] lat_ff;
	logic [W-1:0] out_ff;
	logic [W-1:0] oe_ff;
	logic [W-1:0] pu_ff;
	logic [W-1:0] nxt_dir;
	logic [W-1:0] nxt_lat;

	// ------------------------------------------------------------
	// direction and latch update
	// ------------------------------------------------------------
	// whole-byte write: input pins put their own level into the latch
	always_comb begin
		nxt_dir = dir_we_i ? wdata_i : dir_ff;
		nxt_lat = lat_ff;
		if (lat_we_i) begin
			nxt_lat = (wdata_i & ~dir_ff) | (pins_i & dir_ff);
		end
	end

	// direction resets to all inputs; the latch is left as it was (no power-up
	// distinction here, so a power-up latch stays unknown until its first write)
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			dir_ff <= DIR_RST[W-1:0];
		end else begin
			dir_ff <= nxt_dir;
		end
	end

	// latch has no reset: non-power-up resets leave it unchanged
	always_ff @(posedge clk_i) begin
		lat_ff <= nxt_lat;
	end

	// ------------------------------------------------------------
	// registered pad drive and pull-ups
	// ------------------------------------------------------------
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			out_ff <= '0;
			oe_ff  <= '0;
			pu_ff  <= '0;
		end else begin
			out_ff <= nxt_lat;
			oe_ff  <= ~nxt_dir;
			pu_ff  <= nxt_dir & {W{~pu_en_n_i}};
		end
	end

	assign dir_o = dir_ff;
	assign lat_o = lat_ff;
	assign out_o = out_ff;
	assign oe_o  = oe_ff;
	assign pu_o  = pu_ff;
endmodule

/* File: bpio_pkg.sv */
// package of register offsets, reset values and field positions for the port block
package bpio_pkg;
	// ----------------------------------------------------------------
	// register bus
	// ----------------------------------------------------------------
	localparam int          BPIO_AW         = 8;
	localparam int          BPIO_DW         = 8;
	localparam logic [7:0]  BPIO_OFF_PA     = 8'h00; // port_a_data (pull-up control bit)
	localparam logic [7:0]  BPIO_OFF_PB     = 8'h01; // port_b_data
	localparam logic [7:0]  BPIO_OFF_PORT_B_DIRECTION   = 8'h02; // port_b_direction
	localparam logic [7:0]  BPIO_OFF_PFR    = 8'h03; // peripheral_flag_reg
	localparam logic [7:0]  BPIO_OFF_PER    = 8'h04; // peripheral_enable_reg
	localparam logic [7:0]  BPIO_OFF_SUM    = 8'h05; // summary / wake status
	localparam logic [7:0]  BPIO_OFF_IRQ_ST = 8'h06; // sticky interrupt status
	localparam logic [7:0]  BPIO_OFF_IRQ_EN = 8'h07; // interrupt enable
	localparam logic [7:0]  BPIO_OFF_IRQ_CL = 8'h08; // interrupt clear, write only
	localparam logic [7:0]  BPIO_OFF_PORT_C_DIRECTION   = 8'h10; // port_c_direction
	localparam logic [7:0]  BPIO_OFF_PC     = 8'h11; // port_c_data
	localparam logic [7:0]  BPIO_OFF_CTRL   = 8'h12; // port c bus mode select

	// ----------------------------------------------------------------
	// field positions and reset values
	// ----------------------------------------------------------------
	localparam int          BPIO_PU_BIT     = 7;     // pullup_enable_n in port_a_data
	localparam int          BPIO_CHG_BIT    = 7;     // pin_change_flag in peripheral_flag_reg
	localparam int          BPIO_SUM_BIT    = 0;     // peripheral_summary_flag in summary reg
	localparam int          BPIO_WAKE_BIT   = 1;     // wake request in summary reg
	localparam int          BPIO_EV_CHG     = 0;     // irq event: pin change seen
	localparam int          BPIO_EV_PER     = 1;     // irq event: summary flag rose
	localparam int          BPIO_NEV        = 2;
	localparam logic [7:0]  BPIO_DIR_RST    = 8'hFF;
	localparam logic [7:0]  BPIO_ZERO       = 8'h00;
	localparam logic [7:0]  BPIO_PA_RST     = 8'h00; // pull-ups enabled after any reset
	localparam logic [7:0]  BPIO_PFR_RST    = 8'h00;
endpackage

/* File: bpio_sync.sv */
// two-flop synchroniser for a bus of pin levels
`timescale 1ns/100ps
module bpio_sync #(
	parameter int W = 8
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] q_ff;

	// ------------------------------------------------------------
	// two stages; the first is read only by the second
	// ------------------------------------------------------------
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			meta_ff <= '0;
			q_ff    <= '0;
		end else begin
			meta_ff <= d_i;
			q_ff    <= meta_ff;
		end
	end

	assign q_o = q_ff;
endmodule

/* File: bpio_top.sv */
// bidirectional port b with change interrupt, plus port c with bus mode
`timescale 1ns/100ps
module bpio_top
(
	input  wire logic                        clk_i,
	input  wire logic                        rst_i,
	input  wire logic [bpio_pkg::BPIO_AW-1:0] addr_i,
	input  wire logic [bpio_pkg::BPIO_DW-1:0] wdata_i,
	input  wire logic                        wr_i,
	input  wire logic                        rd_i,
	output logic      [bpio_pkg::BPIO_DW-1:0] rdata_o,
	input  wire logic [7:0]                  port_b_pins_i,
	output logic      [7:0]                  port_b_pins_o,
	output logic      [7:0]                  port_b_pins_oe_o,
	output logic      [7:0]                  port_b_pullup_o,
	input  wire logic [7:0]                  port_c_bus_pin_i,
	output logic      [7:0]                  port_c_bus_pin_o,
	output logic      [7:0]                  port_c_bus_pin_oe_o,
	input  wire logic [7:0]                  sys_bus_addr_data_i,
	input  wire logic                        sys_bus_oe_i,
	output logic      [7:0]                  sys_bus_data_o,
	input  wire logic [6:0]                  periph_flags_i,
	output logic                             wake_o,
	output logic                             irq_o
);
	import bpio_pkg::*;

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic [7:0]          pb_sync;
	logic [7:0]          pc_sync;
	logic [7:0]          pa_ff;
	logic [7:0]          pfr_ff;
	logic [7:0]          per_ff;
	logic [7:0]          rdata_ff;
	logic                bus_mode_ff;
	logic [BPIO_NEV-1:0] irq_st_ff;
	logic [BPIO_NEV-1:0] irq_en_ff;
	logic                irq_ff;
	logic                wake_ff;
	logic                sum_ff;
	logic [7:0]          pc_bus_out_ff;
	logic [7:0]          pc_bus_oe_ff;
	logic [7:0]          sysd_ff;
	logic [7:0]          pb_dir;
	logic [7:0]          pb_lat;
	logic [7:0]          pc_dir;
	logic [7:0]          pc_lat;
	logic [7:0]          pc_gp_out;
	logic [7:0]          pc_gp_oe;
	logic [7:0]          mismatch;
	logic                chg_any;
	logic                summary;
	logic [BPIO_NEV-1:0] ev;
	logic                wr_pa;
	logic                wr_pb;
	logic                wr_port_b_direction;
	logic                wr_pfr;
	logic                wr_per;
	logic                wr_port_c_direction;
	logic                wr_pc;
	logic [7:0]          rd_mux;

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	// async key presses must not reach the comparator raw
	bpio_sync #(.W(8)) u_sync_b (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.d_i   (port_b_pins_i),
		.q_o   (pb_sync)
	);

	// ttl-level pads, same two-stage treatment
	bpio_sync #(.W(8)) u_sync_c (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.d_i   (port_c_bus_pin_i),
		.q_o   (pc_sync)
	);

	// ----------------------------------------------------------------
	// write decode
	// ----------------------------------------------------------------
	// one strobe, one register; unmapped offsets fall through untouched
	// and a write never stalls, so the bus needs no ready signal
	assign wr_pa   = wr_i && (addr_i == BPIO_OFF_PA);
	assign wr_pb   = wr_i && (addr_i == BPIO_OFF_PB);
	assign wr_port_b_direction = wr_i && (addr_i == BPIO_OFF_PORT_B_DIRECTION);
	assign wr_pfr  = wr_i && (addr_i == BPIO_OFF_PFR);
	assign wr_per  = wr_i && (addr_i == BPIO_OFF_PER);
	assign wr_port_c_direction = wr_i && (addr_i == BPIO_OFF_PORT_C_DIRECTION);
	assign wr_pc   = wr_i && (addr_i == BPIO_OFF_PC);

	// ----------------------------------------------------------------
	// port instances
	// ----------------------------------------------------------------
	// port b: latch written at the end of the write cycle, merged with pins
	bpio_pin #(.W(8), .DIR_RST(BPIO_DIR_RST)) u_port_b (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.dir_we_i  (wr_port_b_direction),
		.lat_we_i  (wr_pb),
		.wdata_i   (wdata_i),
		.pins_i    (pb_sync),
		.pu_en_n_i (pa_ff[BPIO_PU_BIT]),
		.dir_o     (pb_dir),
		.lat_o     (pb_lat),
		.out_o     (port_b_pins_o),
		.oe_o      (port_b_pins_oe_o),
		.pu_o      (port_b_pullup_o)
	);

	// port c has no pull-ups; tie the control inactive
	bpio_pin #(.W(8), .DIR_RST(BPIO_DIR_RST)) u_port_c (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.dir_we_i  (wr_port_c_direction),
		.lat_we_i  (wr_pc),
		.wdata_i   (wdata_i),
		.pins_i    (pc_sync),
		.pu_en_n_i (1'b1),
		.dir_o     (pc_dir),
		.lat_o     (pc_lat),
		.out_o     (pc_gp_out),
		.oe_o      (pc_gp_oe),
		.pu_o      ()
	);

	// ----------------------------------------------------------------
	// port a control byte and port c bus mode
	// ----------------------------------------------------------------
	// pull-up control comes out of every reset in its enabling state
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pa_ff <= BPIO_PA_RST;
		end else if (wr_pa) begin
			pa_ff <= wdata_i;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			bus_mode_ff <= 1'b0;
		end else if (wr_i && (addr_i == BPIO_OFF_CTRL)) begin
			bus_mode_ff <= wdata_i[0];
		end
	end

	// bus mode hands the pads to the system bus, else general I/O
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pc_bus_out_ff <= BPIO_ZERO;
			pc_bus_oe_ff  <= BPIO_ZERO;
			sysd_ff       <= BPIO_ZERO;
		end else begin
			pc_bus_out_ff <= bus_mode_ff ? sys_bus_addr_data_i : pc_gp_out;
			pc_bus_oe_ff  <= bus_mode_ff ? {8{sys_bus_oe_i}} : pc_gp_oe;
			sysd_ff       <= pc_sync;
		end
	end

	// ----------------------------------------------------------------
	// change detector and peripheral flags
	// ----------------------------------------------------------------
	// outputs masked out; compare inputs against the latch
	assign mismatch = (pb_sync ^ pb_lat) & pb_dir;
	assign chg_any  = |mismatch;
	assign summary  = |(pfr_ff & per_ff);

	// hardware set wins over a software clear while mismatch lasts
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pfr_ff <= BPIO_PFR_RST;
		end else begin
			if (wr_pfr) begin
				pfr_ff <= wdata_i;
			end
			pfr_ff[6:0] <= wr_pfr ? (wdata_i[6:0] | periph_flags_i) : (pfr_ff[6:0] | periph_flags_i);
			if (chg_any) begin
				pfr_ff[BPIO_CHG_BIT] <= 1'b1;
			end else if (wr_pfr) begin
				pfr_ff[BPIO_CHG_BIT] <= wdata_i[BPIO_CHG_BIT];
			end
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			per_ff <= BPIO_ZERO;
		end else if (wr_per) begin
			per_ff <= wdata_i;
		end
	end

	// wake is level, valid even while the core sleeps
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wake_ff <= 1'b0;
			sum_ff  <= 1'b0;
		end else begin
			wake_ff <= pfr_ff[BPIO_CHG_BIT] & per_ff[BPIO_CHG_BIT];
			sum_ff  <= summary;
		end
	end

	// ----------------------------------------------------------------
	// interrupt status, enable, clear
	// ----------------------------------------------------------------
	assign ev[BPIO_EV_CHG] = chg_any;
	assign ev[BPIO_EV_PER] = summary & ~sum_ff;

	// set beats clear in the same cycle
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			irq_st_ff <= '0;
		end else begin
			if (wr_i && (addr_i == BPIO_OFF_IRQ_CL)) begin
				irq_st_ff <= (irq_st_ff & ~wdata_i[BPIO_NEV-1:0]) | ev;
			end else begin
				irq_st_ff <= irq_st_ff | ev;
			end
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			irq_en_ff <= '0;
			irq_ff    <= 1'b0;
		end else begin
			if (wr_i && (addr_i == BPIO_OFF_IRQ_EN)) begin
				irq_en_ff <= wdata_i[BPIO_NEV-1:0];
			end
			irq_ff <= |(irq_st_ff & irq_en_ff);
		end
	end

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	// data reads show pins sampled before any same-cycle write lands
	always_comb begin
		rd_mux = BPIO_ZERO;
		case (addr_i)
			BPIO_OFF_PA:     rd_mux = pa_ff;
			BPIO_OFF_PB:     rd_mux = pb_sync;
			BPIO_OFF_PORT_B_DIRECTION:   rd_mux = pb_dir;
			BPIO_OFF_PFR:    rd_mux = pfr_ff;
			BPIO_OFF_PER:    rd_mux = per_ff;
			BPIO_OFF_SUM:    rd_mux = {6'h00, wake_ff, summary};
			BPIO_OFF_IRQ_ST: rd_mux = {6'h00, irq_st_ff};
			BPIO_OFF_IRQ_EN: rd_mux = {6'h00, irq_en_ff};
			BPIO_OFF_PORT_C_DIRECTION:   rd_mux = pc_dir;
			BPIO_OFF_PC:     rd_mux = pc_sync;
			BPIO_OFF_CTRL:   rd_mux = {7'h00, bus_mode_ff};
			default:         rd_mux = BPIO_ZERO;
		endcase
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_ff <= BPIO_ZERO;
		end else begin
			rdata_ff <= rd_i ? rd_mux : BPIO_ZERO;
		end
	end

	assign rdata_o             = rdata_ff;
	assign port_c_bus_pin_o    = pc_bus_out_ff;
	assign port_c_bus_pin_oe_o = pc_bus_oe_ff;
	assign sys_bus_data_o      = sysd_ff;
	assign wake_o              = wake_ff;
	assign irq_o               = irq_ff;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	// pad side: pull-ups and drive enables follow the direction register
	pullup_off_out_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(port_b_pins_oe_o != BPIO_ZERO) |-> ((port_b_pins_oe_o & port_b_pullup_o) == BPIO_ZERO))
		else $error("pull-up on while driving");
	pullup_on_in_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!pa_ff[BPIO_PU_BIT] |=> (port_b_pullup_o == pb_dir))
		else $error("pull-ups not on for inputs");
	dir_oe_a: assert property (@(posedge clk_i) disable iff (rst_i)
		1'b1 |=> (port_b_pins_oe_o == ~pb_dir))
		else $error("enable disagrees with direction");
	// change detector: a set survives a clear only while the mismatch lasts
	flag_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
		chg_any |=> pfr_ff[BPIO_CHG_BIT])
		else $error("mismatch did not set flag");
	flag_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr_pfr && !wdata_i[BPIO_CHG_BIT] && !chg_any) |=> !pfr_ff[BPIO_CHG_BIT])
		else $error("flag clear ignored");
	mask_out_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(pb_dir == BPIO_ZERO) |-> !chg_any)
		else $error("output pin compared");
	// latch merge on every port write, both ports alike
	rmw_latch_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_pb |=> (pb_lat == (($past(wdata_i) & ~$past(pb_dir)) | ($past(pb_sync) & $past(pb_dir)))))
		else $error("latch not merged with pins");
	pc_rmw_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_pc |=> (pc_lat == (($past(wdata_i) & ~$past(pc_dir)) | ($past(pc_sync) & $past(pc_dir)))))
		else $error("port c latch not merged");
	// read path: data stand one cycle after the strobe, zero otherwise
	read_pins_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(rd_i && addr_i == BPIO_OFF_PB) |=> (rdata_o == $past(pb_sync)))
		else $error("read did not return pins");
	rd_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!rd_i |=> (rdata_o == BPIO_ZERO))
		else $error("read data without strobe");
	// summary, wake and interrupt levels lag their sources by one edge
	summary_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(|(pfr_ff & per_ff)) |=> sum_ff)
		else $error("summary flag missing");
	wake_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(pfr_ff[BPIO_CHG_BIT] && per_ff[BPIO_CHG_BIT]) |=> wake_o)
		else $error("no wake on pin change");
	wake_drop_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!(pfr_ff[BPIO_CHG_BIT] && per_ff[BPIO_CHG_BIT]) |=> !wake_o)
		else $error("wake without pin change");
	irq_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
		1'b1 |=> (irq_o == $past(|(irq_st_ff & irq_en_ff))))
		else $error("interrupt level wrong");
endmodule

/* File: bpio_top_test.sv */
// self-checking bench for the port block, register tasks and scenarios
`timescale 1ns/100ps
module bpio_top_test;
	import bpio_pkg::*;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic       clk_i, rst_i, wr_i, rd_i, sys_bus_oe_i, wake_o, irq_o;
	logic [7:0] addr_i, wdata_i, rdata_o, sys_bus_addr_data_i, sys_bus_data_o;
	logic [7:0] b_in, b_out, b_oe, b_pu, c_in, c_out, c_oe, key_en, key_val, v;
	logic [6:0] periph_flags_i;
	int         miscompares = 0;
	int         n_tests     = 0;

	bpio_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
		.rd_i(rd_i), .rdata_o(rdata_o), .port_b_pins_i(b_in), .port_b_pins_o(b_out),
		.port_b_pins_oe_o(b_oe), .port_b_pullup_o(b_pu), .port_c_bus_pin_i(c_in),
		.port_c_bus_pin_o(c_out), .port_c_bus_pin_oe_o(c_oe), .sys_bus_addr_data_i(sys_bus_addr_data_i),
		.sys_bus_oe_i(sys_bus_oe_i), .sys_bus_data_o(sys_bus_data_o), .periph_flags_i(periph_flags_i),
		.wake_o(wake_o), .irq_o(irq_o));

	bpio_keypad u_keys (.clk_i(clk_i), .b_drive_i(b_out), .b_oe_i(b_oe), .b_pullup_i(b_pu),
		.key_en_i(key_en), .key_val_i(key_val), .c_drive_i(c_out), .c_oe_i(c_oe),
		.b_level_o(b_in), .c_level_o(c_in));

	// ----------------------------------------------------------------
	// clock, bus tasks, checking
	// ----------------------------------------------------------------
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// one-cycle write strobe, changed right after the edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge clk_i);
		wr_i    <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge clk_i);
		rd_i   <= 1'b0;
		#1;
		d = rdata_o;
	endtask

	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		rd(a, d);
		chk(d, exp);
	endtask

	// waits are settling time for the two-flop pin synchroniser
	task automatic idle(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// a hang gets nearly thirty times the expected run
	initial begin
		repeat (5000) @(posedge clk_i);
		miscompares++;
		$display("watchdog expired");
		give_verdict;
	end

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	initial begin
		rst_i = 1'b1; wr_i = 1'b0; rd_i = 1'b0; addr_i = 8'h00; wdata_i = 8'h00;
		sys_bus_oe_i = 1'b0; sys_bus_addr_data_i = 8'h00; periph_flags_i = 7'h00;
		key_en = 8'hFF; key_val = 8'hFF;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		idle(2);
		chk(b_pu, 8'hFF);
		chk(b_oe, 8'h00);
		rdc(BPIO_OFF_PA, 8'h00);
		rdc(BPIO_OFF_PORT_B_DIRECTION, 8'hFF);
		rdc(BPIO_OFF_PORT_C_DIRECTION, 8'hFF);
		// the port b latch powers up unknown, so settle it before any change compare
		wr(BPIO_OFF_PB, 8'h00);
		wr(BPIO_OFF_PFR, 8'h00);
		wr(BPIO_OFF_IRQ_CL, 8'h03);
		rdc(BPIO_OFF_PFR, 8'h00);
		wr(BPIO_OFF_PA, 8'h80);
		idle(3);
		chk(b_pu, 8'h00);
		wr(BPIO_OFF_PA, 8'h00);
		idle(3);
		chk(b_pu, 8'hFF);
		key_en <= 8'h00;
		$display("test reset and pull-ups done");

		wr(BPIO_OFF_PORT_B_DIRECTION, 8'hF0);
		wr(BPIO_OFF_PB, 8'hA5);
		idle(3);
		chk(b_oe, 8'h0F);
		chk(b_out & 8'h0F, 8'h05);
		chk(b_pu, 8'hF0);
		rdc(BPIO_OFF_PB, 8'hF5);
		wr(BPIO_OFF_PB, 8'h00);
		wr(BPIO_OFF_PORT_B_DIRECTION, 8'h00);
		idle(3);
		chk(b_out, 8'hF0);
		wr(BPIO_OFF_PORT_B_DIRECTION, 8'hF0);
		rdc(BPIO_OFF_PFR, 8'h00);
		// force an output pad against its latch: must not count as a change
		key_en  <= 8'h01;
		key_val <= 8'h01;
		idle(6);
		rdc(BPIO_OFF_PFR, 8'h00);
		key_en <= 8'h00;
		$display("test direction and latch done");

		wr(BPIO_OFF_PER, 8'h80);
		wr(BPIO_OFF_IRQ_EN, 8'h01);
		key_en  <= 8'h80;
		key_val <= 8'h00;
		idle(6);
		chk({7'h00, irq_o}, 8'h01);
		chk({7'h00, wake_o}, 8'h01);
		rdc(BPIO_OFF_PFR, 8'h80);
		wr(BPIO_OFF_PFR, 8'h00);
		rdc(BPIO_OFF_PFR, 8'h80);
		rd(BPIO_OFF_PB, v);
		chk(v, 8'h70);
		idle(1);
		wr(BPIO_OFF_PB, v);
		idle(4);
		wr(BPIO_OFF_PFR, 8'h00);
		rdc(BPIO_OFF_PFR, 8'h00);
		wr(BPIO_OFF_IRQ_CL, 8'h03);
		idle(3);
		chk({7'h00, irq_o}, 8'h00);
		chk({7'h00, wake_o}, 8'h00);
		key_en <= 8'h00;
		idle(6);
		rdc(BPIO_OFF_PFR, 8'h80);
		chk({7'h00, irq_o}, 8'h01);
		wr(BPIO_OFF_IRQ_EN, 8'h00);
		idle(3);
		chk({7'h00, irq_o}, 8'h00);
		wr(BPIO_OFF_PB, 8'h00);
		wr(BPIO_OFF_PFR, 8'h00);
		wr(BPIO_OFF_IRQ_CL, 8'h03);
		wr(BPIO_OFF_PER, 8'h00);
		$display("test change interrupt done");

		@(posedge clk_i);
		periph_flags_i <= 7'h01;
		@(posedge clk_i);
		periph_flags_i <= 7'h00;
		rdc(BPIO_OFF_PFR, 8'h01);
		rdc(BPIO_OFF_SUM, 8'h00);
		wr(BPIO_OFF_PER, 8'h01);
		rdc(BPIO_OFF_SUM, 8'h01);
		// only the summary rise is pending: the change event was cleared
		rdc(BPIO_OFF_IRQ_ST, 8'h02);
		wr(BPIO_OFF_PER, 8'h00);
		rdc(BPIO_OFF_SUM, 8'h00);
		wr(BPIO_OFF_PFR, 8'h00);
		wr(BPIO_OFF_IRQ_CL, 8'h03);
		rdc(BPIO_OFF_IRQ_ST, 8'h00);
		$display("test summary flag done");

		wr(BPIO_OFF_PORT_C_DIRECTION, 8'h00);
		wr(BPIO_OFF_PC, 8'h3C);
		idle(3);
		chk(c_oe, 8'hFF);
		chk(c_out, 8'h3C);
		rdc(BPIO_OFF_PC, 8'h3C);
		wr(BPIO_OFF_CTRL, 8'h01);
		rdc(BPIO_OFF_CTRL, 8'h01);
		sys_bus_oe_i        <= 1'b1;
		sys_bus_addr_data_i <= 8'h96;
		idle(4);
		chk(c_out, 8'h96);
		chk(sys_bus_data_o, 8'h96);
		sys_bus_oe_i <= 1'b0;
		wr(BPIO_OFF_CTRL, 8'h00);
		rdc(8'h20, 8'h00);
		rdc(BPIO_OFF_IRQ_CL, 8'h00);
		$display("test port c and unmapped done");

		// second reset mid-run: the latch must survive it
		@(posedge clk_i);
		rst_i <= 1'b1;
		idle(2);
		rst_i <= 1'b0;
		idle(2);
		chk(b_pu, 8'hFF);
		wr(BPIO_OFF_PORT_B_DIRECTION, 8'h00);
		idle(3);
		chk(b_out, 8'hF0);
		rdc(BPIO_OFF_PA, 8'h00);
		$display("test warm reset done");
		give_verdict;
	end
endmodule
